//--- inc/bio_defs.svh
// constants for the bus i/o line diagnosis and safety block
`ifndef BIO_DEFS_SVH
`define BIO_DEFS_SVH

// command and status bit positions
`define BIO_B_SURV_INH 3
`define BIO_B_BUSY 7
`define BIO_B_MOD_HI 6
`define BIO_B_MOD_LO 4
`define BIO_B_FORCED 2
`define BIO_ST_AGREE 2
`define BIO_ST_SAFETY 3
`define BIO_CMD_RESET 8'h00

// receive-line codes
`define BIO_CODE_TRANSP 3'h3
`define BIO_CODE_FORCE_EQ 3'h7
`define BIO_LINE_FIRST 2'h0
`define BIO_LINE_LAST 2'h2
`define BIO_DOMINANT 1'b0

// port write lengths in bytes
`define BIO_LEN_VALUE 3'h1
`define BIO_LEN_DIR 3'h2
`define BIO_LEN_OPT 3'h3
`define BIO_PORT_OFF 8'h00
`define BIO_PORT_ALL 8'hFF

// timing
`define BIO_CLK_MHZ 100
`define BIO_SAFE_CLK_KHZ 500
`define BIO_T_BASE_MS 1000
`define BIO_SHORT_DIV 16
`define BIO_MEDIUM_DIV 4
`define BIO_SUPER_MUL 4
`define BIO_INT_DIV (`BIO_CLK_MHZ * 1000 / `BIO_SAFE_CLK_KHZ)
`define BIO_DIV_W 8
`define BIO_SRC_SWITCH_CYC 6'h20
`define BIO_SRC_W 6
`define BIO_TO_W 24

`endif

//--- inc/bio_pkg.sv
// types for the bus i/o line diagnosis and safety block
package bio_pkg;
  typedef enum logic [2:0] {
    BIO_ST_INIT = 3'b001,
    BIO_ST_RUN = 3'b010,
    BIO_ST_SAFE = 3'b100
  } bio_diag_t;
  typedef logic [1:0] bio_line_t;
  typedef logic [7:0] bio_byte_t;
endpackage : bio_pkg

//--- rtl/bio_timeout.sv
// periodic time-out counter on the safety tick
`timescale 1ns/1ps
`default_nettype none
`include "bio_defs.svh"
module bio_timeout (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic tick,
  input wire logic restart,
  input wire logic [`BIO_TO_W-1:0] limit,
  // event
  output logic expired_q
);
  localparam logic [`BIO_TO_W-1:0] ONE = `BIO_TO_W'(1);
  logic [`BIO_TO_W-1:0] cnt_q;
  logic at_end;

  assign at_end = tick && (cnt_q == limit - ONE);

  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      cnt_q <= '0;
    end else if (at_end) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= at_end && !restart;
    end
  end

  a_expire_count: assert property (@(posedge clk) disable iff (sys_rst)
    expired_q |-> $past(cnt_q) == limit - ONE && cnt_q == '0)
    else $error("time-out fired at wrong count");
endmodule : bio_timeout
`default_nettype wire

//--- rtl/bio_top.sv
// line diagnosis, safety supervisor, command/status and port pins
// Contract
// - opt0 dir0 inputs, opt0 dir1 drives value
// - time-outs are T/16, T/4, T, 4T
// - short fires on overlong dominant bus
// - medium: no frames; long: none addressing us
// - time-outs counted on the safety clock
// - three command bits choose line mode
// - automatic mode steps lines 0, 1, 2
// - transparent code keeps line, updates B7..B3
// - forced mode keeps line despite time-outs
// - status low bits: line and agreement
// - agreement means all high or all low
// - B3 set inhibits surveillance and safety
// - status B3 shows safety mode
// - inhibited: interrupt after each addressed frame
// - B6..B4 module, B7 busy, echoed
// - command writes always accepted, port writes only of 1..3 bytes
// - reset clears command, ports high-z, int low
// - safety: port A high-z, B kept, int high; a port A write in the entry cycle wins over the release
// - after reset, super-long silence enters safety
// - frames but no access for long: safety
// - port A write leaves safety, int low
// - port write of 1..3 bytes, else rejected
// - safety clock source switches after 32 cycles
`timescale 1ns/1ps
`default_nettype none
`include "bio_defs.svh"
module bio_top #(
  parameter int unsigned T_TICKS = `BIO_T_BASE_MS * `BIO_SAFE_CLK_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // receive line pins
  input wire logic receive_line_differential,
  input wire logic receive_line_true,
  input wire logic receive_line_complement,
  output logic rx_selected_q,
  // frame controller events
  input wire logic frm_coherent,
  input wire logic frm_addressed,
  // command write
  input wire logic cmd_wr_stb,
  input wire bio_pkg::bio_byte_t cmd_wr_data,
  // port writes
  input wire logic pa_wr_stb,
  input wire logic pb_wr_stb,
  input wire logic [2:0] pw_len,
  input wire bio_pkg::bio_byte_t pw_value,
  input wire bio_pkg::bio_byte_t pw_dir,
  input wire bio_pkg::bio_byte_t pw_opt,
  // read data
  output bio_pkg::bio_byte_t line_and_access_status_q,
  output bio_pkg::bio_byte_t port_a_rd_q,
  output bio_pkg::bio_byte_t port_b_rd_q,
  // port pins
  input wire bio_pkg::bio_byte_t first_io_port_in,
  output bio_pkg::bio_byte_t first_io_port_out,
  output bio_pkg::bio_byte_t first_io_port_oe_n,
  input wire bio_pkg::bio_byte_t second_io_port_in,
  output bio_pkg::bio_byte_t second_io_port_out,
  output bio_pkg::bio_byte_t second_io_port_oe_n,
  // safety clock and interrupt
  input wire logic safety_clock_pin,
  output logic safety_int_q
);
  import bio_pkg::*;

  localparam logic [`BIO_TO_W-1:0] LIM_S = `BIO_TO_W'(T_TICKS / `BIO_SHORT_DIV);
  localparam logic [`BIO_TO_W-1:0] LIM_M = `BIO_TO_W'(T_TICKS / `BIO_MEDIUM_DIV);
  localparam logic [`BIO_TO_W-1:0] LIM_L = `BIO_TO_W'(T_TICKS);
  localparam logic [`BIO_TO_W-1:0] LIM_SL = `BIO_TO_W'(T_TICKS * `BIO_SUPER_MUL);
  localparam logic [`BIO_DIV_W-1:0] DIV_END = `BIO_DIV_W'(`BIO_INT_DIV - 1);

  function automatic bio_line_t next_line(input bio_line_t l);
    next_line = (l == `BIO_LINE_LAST) ? `BIO_LINE_FIRST : l + 2'h1;
  endfunction : next_line

  logic [2:0] rx_s1_q, rx_s2_q;
  bio_byte_t pa_s1_q, pb_s1_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  bio_byte_t line_and_access_command_q;
  bio_line_t line_q;
  logic auto_q;
  bio_diag_t state_q, state_d;
  logic coh_seen_q;
  bio_byte_t port_output_value_q [2];
  bio_byte_t port_direction_q [2];
  bio_byte_t port_option_q [2];
  logic [`BIO_SRC_W-1:0] src_cnt_q;
  logic src_ext_q;
  logic [`BIO_DIV_W-1:0] div_q;
  logic int_tick, ext_tick, tick, agree, surv_on, enter_safe;
  logic pa_wr_ok, pb_wr_ok, len_ok;
  logic sto_q, mto_q, lto_q, super_long_timeout_q;
  logic [2:0] code;

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_s1_q <= 3'h0;
      rx_s2_q <= 3'h0;
    end else begin
      rx_s1_q <= {receive_line_complement, receive_line_true, receive_line_differential};
      rx_s2_q <= rx_s1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pa_s1_q <= 8'h00;
      pb_s1_q <= 8'h00;
      port_a_rd_q <= 8'h00;
      port_b_rd_q <= 8'h00;
    end else begin
      pa_s1_q <= first_io_port_in;
      pb_s1_q <= second_io_port_in;
      port_a_rd_q <= pa_s1_q;
      port_b_rd_q <= pb_s1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else begin
      sck_s1_q <= safety_clock_pin;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  // safety tick: internal divider, then the external pin clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= '0;
    end else begin
      div_q <= int_tick ? '0 : div_q + `BIO_DIV_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_cnt_q <= '0;
      src_ext_q <= 1'b0;
    end else if (!src_ext_q) begin
      src_cnt_q <= src_cnt_q + `BIO_SRC_W'(1);
      src_ext_q <= (src_cnt_q == `BIO_SRC_SWITCH_CYC - `BIO_SRC_W'(1));
    end
  end

  assign int_tick = (div_q == DIV_END);
  assign ext_tick = sck_s2_q && !sck_s3_q;
  assign tick = src_ext_q ? ext_tick : int_tick;

  assign agree = (&rx_s2_q) || !(|rx_s2_q);
  assign surv_on = !line_and_access_command_q[`BIO_B_SURV_INH];
  assign code = cmd_wr_data[2:0];
  assign len_ok = (pw_len >= `BIO_LEN_VALUE) && (pw_len <= `BIO_LEN_OPT);
  assign pa_wr_ok = pa_wr_stb && len_ok;
  assign pb_wr_ok = pb_wr_stb && len_ok;

  // command register, written in any state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_and_access_command_q <= `BIO_CMD_RESET;
    end else if (cmd_wr_stb) begin
      line_and_access_command_q[7:3] <= cmd_wr_data[7:3];
      if (code != `BIO_CODE_TRANSP) begin
        line_and_access_command_q[2:0] <= code;
      end
    end
  end

  // line selection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_q <= `BIO_LINE_FIRST;
      auto_q <= 1'b1;
    end else if (cmd_wr_stb && code != `BIO_CODE_TRANSP) begin
      auto_q <= !code[`BIO_B_FORCED];
      line_q <= (code == `BIO_CODE_FORCE_EQ) ? `BIO_LINE_FIRST : code[1:0];
    end else if (auto_q && (mto_q || lto_q)) begin
      line_q <= next_line(line_q);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_selected_q <= 1'b1;
    end else begin
      rx_selected_q <= rx_s2_q[line_q];
    end
  end

  // time-outs
  bio_timeout u_short (.clk(clk), .sys_rst(sys_rst), .tick(tick),
    .restart(rx_selected_q != `BIO_DOMINANT), .limit(LIM_S), .expired_q(sto_q));
  bio_timeout u_medium (.clk(clk), .sys_rst(sys_rst), .tick(tick),
    .restart(frm_coherent), .limit(LIM_M), .expired_q(mto_q));
  bio_timeout u_long (.clk(clk), .sys_rst(sys_rst), .tick(tick),
    .restart(frm_addressed), .limit(LIM_L), .expired_q(lto_q));
  bio_timeout u_super (.clk(clk), .sys_rst(sys_rst), .tick(tick),
    .restart(frm_addressed), .limit(LIM_SL), .expired_q(super_long_timeout_q));

  // coherent traffic seen during the current long window; a new frame wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      coh_seen_q <= 1'b0;
    end else if (frm_coherent) begin
      coh_seen_q <= 1'b1;
    end else if (frm_addressed || lto_q) begin
      coh_seen_q <= 1'b0;
    end
  end

  // safety supervisor
  always_comb begin
    state_d = state_q;
    case (state_q)
      BIO_ST_INIT: begin
        if (frm_addressed) begin
          state_d = BIO_ST_RUN;
        end else if (surv_on && super_long_timeout_q) begin
          state_d = BIO_ST_SAFE;
        end
      end
      BIO_ST_RUN: begin
        if (surv_on && lto_q && (coh_seen_q || frm_coherent)) begin
          state_d = BIO_ST_SAFE;
        end
      end
      BIO_ST_SAFE: begin
        if (pa_wr_ok) begin
          state_d = BIO_ST_RUN;
        end
      end
      default: state_d = BIO_ST_INIT;
    endcase
  end

  assign enter_safe = (state_d == BIO_ST_SAFE) && (state_q != BIO_ST_SAFE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= BIO_ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      safety_int_q <= 1'b0;
    end else begin
      safety_int_q <= (state_d == BIO_ST_SAFE) || (!surv_on && frm_addressed);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_and_access_status_q <= 8'h00;
    end else begin
      line_and_access_status_q <= {line_and_access_command_q[7:4],
        state_q == BIO_ST_SAFE, agree, 1'b0, line_q[0]} | {6'h00, line_q[1], 1'b0};
    end
  end

  // port registers; a write in the entry cycle wins over the port A release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int p = 0; p < 2; p++) begin
        port_output_value_q[p] <= `BIO_PORT_OFF;
        port_direction_q[p] <= `BIO_PORT_OFF;
        port_option_q[p] <= `BIO_PORT_OFF;
      end
    end else begin
      if (enter_safe) begin
        port_direction_q[0] <= `BIO_PORT_OFF;
      end
      for (int p = 0; p < 2; p++) begin
        if ((p == 0) ? pa_wr_ok : pb_wr_ok) begin
          port_output_value_q[p] <= pw_value;
          port_direction_q[p] <= (pw_len == `BIO_LEN_VALUE) ? `BIO_PORT_ALL : pw_dir;
          if (pw_len == `BIO_LEN_OPT) begin
            port_option_q[p] <= pw_opt;
          end
        end
      end
    end
  end

  // option bits set are not driven
  assign first_io_port_out = port_output_value_q[0];
  assign first_io_port_oe_n = ~(port_direction_q[0] & ~port_option_q[0]);
  assign second_io_port_out = port_output_value_q[1];
  assign second_io_port_oe_n = ~(port_direction_q[1] & ~port_option_q[1]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_enter_safe;
    state_q != BIO_ST_SAFE ##1 state_q == BIO_ST_SAFE;
  endsequence

  a_pin_drive: assert property (pa_wr_ok && pw_len == `BIO_LEN_VALUE
    |=> first_io_port_oe_n == `BIO_PORT_OFF && first_io_port_out == $past(pw_value))
    else $error("programmed output pin not driven");
  a_transp_keep: assert property (cmd_wr_stb && code == `BIO_CODE_TRANSP
    |=> $stable(line_q) && line_and_access_command_q[7:3] == $past(cmd_wr_data[7:3]))
    else $error("transparent write moved the line");
  a_forced_hold: assert property (!auto_q && !cmd_wr_stb |=> $stable(line_q))
    else $error("forced line changed");
  a_auto_step: assert property (auto_q && !cmd_wr_stb && (mto_q || lto_q)
    |=> line_q == next_line($past(line_q)))
    else $error("automatic mode did not step line");
  a_agree_status: assert property (1'b1
    |=> line_and_access_status_q[`BIO_ST_AGREE] == $past(agree))
    else $error("agreement status wrong");
  a_inhib_safe: assert property (!surv_on && state_q != BIO_ST_SAFE
    |=> state_q != BIO_ST_SAFE)
    else $error("safety entered while inhibited");
  a_safe_status: assert property (state_q == BIO_ST_SAFE
    |=> line_and_access_status_q[`BIO_ST_SAFETY])
    else $error("safety status bit missing");
  a_inhib_int: assert property (!surv_on && frm_addressed |=> safety_int_q)
    else $error("no interrupt after addressed frame");
  a_busy_echo: assert property (cmd_wr_stb |-> ##2
    line_and_access_status_q[7:4] == $past(cmd_wr_data[7:4], 2))
    else $error("busy and module not echoed");
  a_safe_entry: assert property (s_enter_safe |-> safety_int_q
    && first_io_port_oe_n == `BIO_PORT_ALL || $past(pa_wr_ok))
    else $error("safety entry outputs wrong");
  a_safe_exit: assert property (state_q == BIO_ST_SAFE && pa_wr_ok
    |=> state_q == BIO_ST_RUN && !(safety_int_q && surv_on))
    else $error("port A write did not leave safety");
  a_len_reject: assert property (pb_wr_stb && !len_ok |=> $stable(port_output_value_q[1]))
    else $error("bad length write accepted");
  a_src_switch: assert property ($rose(src_ext_q) |-> src_cnt_q == `BIO_SRC_SWITCH_CYC)
    else $error("safety clock switched at wrong time");
  a_short_fire: assert property (sto_q |-> $past(rx_selected_q) == `BIO_DOMINANT)
    else $error("short time-out fired on recessive bus");
endmodule : bio_top
`default_nettype wire

//--- tb/bio_master_model.sv
// bus master model: frame events, command writes and port writes
`timescale 1ns/1ps
`default_nettype none
module bio_master_model (
  // clock
  input wire logic clk,
  // frame events
  output logic frm_coherent,
  output logic frm_addressed,
  // command write
  output logic cmd_wr_stb,
  output logic [7:0] cmd_wr_data,
  // port writes
  output logic pa_wr_stb,
  output logic pb_wr_stb,
  output logic [2:0] pw_len,
  output logic [7:0] pw_value,
  output logic [7:0] pw_dir,
  output logic [7:0] pw_opt
);
  initial begin
    {frm_coherent, frm_addressed, cmd_wr_stb, pa_wr_stb, pb_wr_stb} = 5'h00;
    {cmd_wr_data, pw_value, pw_dir, pw_opt} = 32'hA5A5A5A5;
    pw_len = 3'h0;
  end
  task automatic ev(input logic coh);
    @(negedge clk);
    frm_coherent = coh;
    frm_addressed = ~coh;
    @(negedge clk);
    frm_coherent = 1'b0;
    frm_addressed = 1'b0;
  endtask : ev
  task automatic cmd(input logic [7:0] d);
    @(negedge clk);
    cmd_wr_data = d;
    cmd_wr_stb = 1'b1;
    @(negedge clk);
    cmd_wr_stb = 1'b0;
    cmd_wr_data = ~d;
  endtask : cmd
  task automatic pw(input logic b, input logic [2:0] len, input logic [7:0] v, d);
    @(negedge clk);
    pa_wr_stb = ~b;
    pb_wr_stb = b;
    pw_len = len;
    pw_value = len == 3'h1 ? v : v & d;
    pw_dir = d;
    pw_opt = 8'h00;
    @(negedge clk);
    {pa_wr_stb, pb_wr_stb} = 2'h0;
    pw_value = ~pw_value;
    pw_dir = ~d;
    pw_opt = 8'hFF;
  endtask : pw
endmodule : bio_master_model
`default_nettype wire

//--- tb/bus_io_line_diagnosis_safety_bench.sv
// self-checking bench for the line diagnosis and safety block
`timescale 1ns/1ps
`default_nettype none
module bus_io_line_diagnosis_safety_bench;
  import bio_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hpin;
  logic [2:0] rx;
  logic [31:0] lfsr = 32'hE81DD216;
  int err_total = 0;
  int check_count = 0;
  int k;
  logic fc, fa, cs, pas, pbs, rsel, irq;
  logic [2:0] pl;
  bio_byte_t cd, pv, pd, po, st, ard, brd, ao, aoe, bo, boe;
  bio_byte_t aext;
  bio_byte_t bext;
  bio_byte_t pa_pin;
  bio_byte_t pb_pin;
  bio_byte_t eo [2];
  bio_byte_t eoe [2];
  logic [2:0] codes [5] = '{3'h5, 3'h3, 3'h6, 3'h7, 3'h4};
  logic [2:0] lens [6] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h3};
  logic [1:0] ln;
  logic [31:0] r;
  bio_byte_t v, d;
  always #5 clk = ~clk;
  // safety clock pin toggles at a scaled-down rate
  always #20 hpin = ~hpin;
  // pins read back what the block drives, else the outside level
  assign pa_pin = (ao & ~aoe) | (aext & aoe);
  assign pb_pin = (bo & ~boe) | (bext & boe);
  bio_master_model bio_master_model_inst (.clk(clk), .frm_coherent(fc), .frm_addressed(fa),
    .cmd_wr_stb(cs), .cmd_wr_data(cd), .pa_wr_stb(pas), .pb_wr_stb(pbs), .pw_len(pl),
    .pw_value(pv), .pw_dir(pd), .pw_opt(po));
  bio_top #(.T_TICKS(32)) bio_top_inst (.clk(clk), .sys_rst(sys_rst),
    .receive_line_differential(rx[0]), .receive_line_true(rx[1]),
    .receive_line_complement(rx[2]), .rx_selected_q(rsel), .frm_coherent(fc),
    .frm_addressed(fa), .cmd_wr_stb(cs), .cmd_wr_data(cd), .pa_wr_stb(pas), .pb_wr_stb(pbs),
    .pw_len(pl), .pw_value(pv), .pw_dir(pd), .pw_opt(po), .line_and_access_status_q(st),
    .port_a_rd_q(ard), .port_b_rd_q(brd), .first_io_port_in(pa_pin),
    .first_io_port_out(ao), .first_io_port_oe_n(aoe),
    .second_io_port_in(pb_pin), .second_io_port_out(bo),
    .second_io_port_oe_n(boe), .safety_clock_pin(hpin), .safety_int_q(irq));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic chk8(input bio_byte_t g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk1
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
  endtask : do_reset
  task automatic wait_int(input int n, input logic val);
    k = 0;
    while (irq !== val && k < n) begin
      @(negedge clk);
      k++;
    end
    chk1(irq, val);
  endtask : wait_int
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    hpin = 1'b0;
    rx = 3'h7;
    aext = 8'h00;
    bext = 8'h00;
    do_reset();
    chk8(st & 8'hFB, 8'h00);
    chk8(aoe, 8'hFF);
    chk8(boe, 8'hFF);
    chk1(irq, 1'b0);
    $display("test reset done");
    bio_master_model_inst.ev(1'b0);
    ln = 2'h0;
    foreach (codes[i]) begin
      r = rnd();
      rx = r[10:8];
      d = {r[7:4], 1'b0, codes[i]};
      bio_master_model_inst.cmd(d);
      if (codes[i] != 3'h3) ln = codes[i] == 3'h7 ? 2'h0 : codes[i][1:0];
      repeat (4) @(negedge clk);
      chk8(st, {d[7:4], 1'b0, (rx == 3'h0 || rx == 3'h7), ln});
      chk1(rsel, rx[ln]);
    end
    $display("test command done");
    eo = '{8'h00, 8'h00};
    eoe = '{8'hFF, 8'hFF};
    foreach (lens[i]) begin
      r = rnd();
      v = r[7:0];
      d = r[15:8];
      aext = r[23:16];
      bext = r[31:24];
      bio_master_model_inst.pw(i[0], lens[i], v, d);
      if (lens[i] inside {[3'h1:3'h3]}) begin
        eo[i % 2] = lens[i] == 3'h1 ? v : v & d;
        eoe[i % 2] = lens[i] == 3'h1 ? 8'h00 : ~d;
      end
      repeat (4) @(negedge clk);
      chk8(i[0] ? bo : ao, eo[i % 2]);
      chk8(i[0] ? boe : aoe, eoe[i % 2]);
      chk8(i[0] ? brd : ard, (eo[i % 2] & ~eoe[i % 2]) | ((i[0] ? bext : aext) & eoe[i % 2]));
    end
    $display("test ports done");
    // restart medium and long windows so no step lands inside the first check
    bio_master_model_inst.ev(1'b1);
    bio_master_model_inst.ev(1'b0);
    bio_master_model_inst.cmd(8'h01);
    repeat (3) @(negedge clk);
    ln = 2'h1;
    chk8(st & 8'h03, 8'h01);
    repeat (4) begin
      k = 0;
      while (st[1:0] === ln && k < 300) begin
        @(negedge clk);
        k++;
      end
      ln = ln == 2'h2 ? 2'h0 : ln + 2'h1;
      chk8(st & 8'h03, {6'h00, ln});
    end
    bio_master_model_inst.cmd(8'h06);
    repeat (300) @(negedge clk);
    chk8(st & 8'h03, 8'h02);
    $display("test lines done");
    do_reset();
    bio_master_model_inst.pw(1'b1, 3'h3, 8'h5A, 8'h0F);
    bio_master_model_inst.pw(1'b0, 3'h3, 8'h3C, 8'hF0);
    repeat (300) @(negedge clk);
    chk1(irq, 1'b0);
    wait_int(900, 1'b1);
    repeat (2) @(negedge clk);
    chk8(st & 8'h08, 8'h08);
    chk8(aoe, 8'hFF);
    chk8(boe, 8'hF0);
    chk8(bo, 8'h0A);
    bio_master_model_inst.pw(1'b0, 3'h1, 8'h77, 8'h00);
    wait_int(4, 1'b0);
    repeat (2) @(negedge clk);
    chk8(st & 8'h08, 8'h00);
    $display("test safety done");
    do_reset();
    bio_master_model_inst.ev(1'b0);
    k = 0;
    while (irq !== 1'b1 && k < 60) begin
      bio_master_model_inst.ev(1'b1);
      repeat (14) @(negedge clk);
      k++;
    end
    chk1(irq, 1'b1);
    chk1(k > 5, 1'b1);
    $display("test operation done");
    do_reset();
    bio_master_model_inst.cmd(8'h08);
    repeat (900) @(negedge clk);
    chk1(irq, 1'b0);
    bio_master_model_inst.ev(1'b0);
    wait_int(4, 1'b1);
    @(negedge clk);
    chk1(irq, 1'b0);
    $display("test inhibit done");
    test_done();
  end
endmodule : bus_io_line_diagnosis_safety_bench
`default_nettype wire
